/* core/gfsm_defines.vh */
// Constants for the pin output function multiplexer: field layout, reset values, function codes.
// Assumes inclusion by bare name from design files under core/.
`ifndef GFSM_DEFINES_VH
`define GFSM_DEFINES_VH

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define GFSM_FN_MSB          6
`define GFSM_FN_LSB          0
`define GFSM_FN_RESET        7'h01
`define GFSM_DIR_RESET       1'b1
`define GFSM_DIR_OUTPUT      1'b0
`define GFSM_PINS            5

// ----------------------------------------
// Function codes
// ----------------------------------------
`define GFSM_FN_NONE         7'h00
`define GFSM_FN_LEVEL        7'h01
`define GFSM_FN_IRQ_ONE      7'h02
`define GFSM_FN_IRQ_TWO      7'h03
`define GFSM_FN_DERIVED_CLK  7'h04
`define GFSM_FN_LOOP1_CLK    7'h05
`define GFSM_FN_LOOP2_CLK    7'h06
`define GFSM_FN_SPDIF        7'h07
`define GFSM_FN_PULSE_WIDTH_CHANNEL_ONE         7'h08
`define GFSM_FN_PULSE_WIDTH_CHANNEL_TWO         7'h09
`define GFSM_FN_SYS_UNDER    7'h0a
`define GFSM_FN_ASYNC_UNDER  7'h0b
`define GFSM_FN_LOOP1_LOCK   7'h0c
`define GFSM_FN_LOOP2_LOCK   7'h0d
`define GFSM_FN_LOOP1_OK     7'h0f
`define GFSM_FN_LOOP2_OK     7'h10
`define GFSM_FN_HP_DETECT    7'h12
`define GFSM_FN_MIC_DETECT   7'h13
`define GFSM_FN_SEQ_DONE     7'h15
`define GFSM_FN_ADDR_ERR     7'h16
`define GFSM_FN_ARC1_LOCK    7'h1a
`define GFSM_FN_ARC2_LOCK    7'h1b
`define GFSM_FN_ARC_CFG_ERR  7'h1c
`define GFSM_FN_DYN_SIGNAL   7'h1d
`define GFSM_FN_DYN_CLIP     7'h1e
`define GFSM_FN_DYN_DECAY    7'h1f
`define GFSM_FN_DYN_GATE     7'h20
`define GFSM_FN_DYN_QUICK    7'h21

// ----------------------------------------
// Timing
// ----------------------------------------
`define GFSM_CLK_PERIOD_PS   5000
`define GFSM_MIC_PULSE_NS    31000
`define GFSM_MIC_PULSE_CYC   ((`GFSM_MIC_PULSE_NS * 1000) / `GFSM_CLK_PERIOD_PS)
`define GFSM_MIC_CNT_W       13
`define GFSM_SEQ_PULSE_CYC   4

`endif

/* core/gfsm_pulse_stretch.v */
// Fixed-length pulse stretcher: one-cycle event in, pulse of LEN cycles out.
// Assumes the trigger is synchronous to core_clk; retriggering restarts the pulse.
`timescale 1ns/1ps

module gfsm_pulse_stretch #(
	parameter LEN = 4,
	parameter W   = 13
) (
	input  wire core_clk,
	input  wire rst_n,
	input  wire trigger,
	output reg  pulse
);
	reg [W-1:0] count;

	// Count down from LEN-1; a new event restarts so each event gives at least one full pulse
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= {W{1'b0}};
			pulse <= 1'b0;
		end else if (trigger) begin
			count <= LEN[W-1:0] - {{(W-1){1'b0}}, 1'b1};
			pulse <= 1'b1;
		end else if (count != {W{1'b0}}) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
			pulse <= 1'b1;
		end else begin
			pulse <= 1'b0;
		end
	end
endmodule // gfsm_pulse_stretch

/* core/gfsm_pin_mux.v */
// Output function multiplexer for five general-purpose pins.
// Assumes every source arrives from another clock domain and is resynchronised here;
// clock sources are sampled, so they appear at the pin at a rate well below core_clk.
`timescale 1ns/1ps
`include "gfsm_defines.vh"

module gfsm_pin_mux (
	input  wire        core_clk,
	input  wire        rst_n,
	// Per-pin control, five pins packed low pin first
	input  wire [34:0] pin_function_select,
	input  wire [4:0]  pin_direction,
	input  wire [4:0]  pin_level_bit,
	input  wire [4:0]  output_polarity,
	input  wire [4:0]  pin_in,
	// Sources
	input  wire        interrupt_line_one,
	input  wire        interrupt_line_two,
	input  wire        derived_clock_out,
	input  wire        locked_loop_one_clk,
	input  wire        locked_loop_two_clk,
	input  wire        spdif_stream,
	input  wire        pulse_width_channel_one,
	input  wire        pulse_width_channel_two,
	input  wire        system_clock_underclocked,
	input  wire        async_clock_underclocked,
	input  wire        locked_loop_one_lock,
	input  wire        locked_loop_two_lock,
	input  wire        locked_loop_one_ok,
	input  wire        locked_loop_two_ok,
	input  wire        mic_accessory_detect_event,
	input  wire        sequencer_done_event,
	input  wire        control_address_error,
	input  wire        async_rate_converter_one_lock,
	input  wire        async_rate_converter_two_lock,
	input  wire        async_rate_converter_config_error,
	input  wire        dynamics_processor_one_signal,
	input  wire        dynamics_processor_one_clip,
	input  wire        dynamics_processor_one_decay,
	input  wire        dynamics_processor_one_gate,
	input  wire        dynamics_processor_one_quick,
	// Pin side
	output reg  [4:0]  pin_out,
	output reg  [4:0]  pin_oe,
	output reg  [4:0]  pin_level_read
);

	// ----------------------------------------
	// Source synchronisers
	// ----------------------------------------
	localparam NSRC = 25;
	localparam NPIN = `GFSM_PINS;

	wire [NSRC-1:0] src_raw;
	reg  [NSRC-1:0] src_meta;
	reg  [NSRC-1:0] src;
	reg  [NPIN-1:0] pin_meta;
	reg  [NPIN-1:0] pin_sync;

	assign src_raw = {dynamics_processor_one_quick, dynamics_processor_one_gate,
		dynamics_processor_one_decay, dynamics_processor_one_clip,
		dynamics_processor_one_signal, async_rate_converter_config_error,
		async_rate_converter_two_lock, async_rate_converter_one_lock,
		control_address_error, sequencer_done_event, mic_accessory_detect_event,
		locked_loop_two_ok, locked_loop_one_ok, locked_loop_two_lock,
		locked_loop_one_lock, async_clock_underclocked, system_clock_underclocked,
		pulse_width_channel_two, pulse_width_channel_one, spdif_stream,
		locked_loop_two_clk, locked_loop_one_clk, derived_clock_out,
		interrupt_line_two, interrupt_line_one};

	// Two flops on every source and on pin_in; only the second stage is read
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_meta <= {NSRC{1'b0}};
			src      <= {NSRC{1'b0}};
			pin_meta <= {NPIN{1'b0}};
			pin_sync <= {NPIN{1'b0}};
		end else begin
			src_meta <= src_raw;
			src      <= src_meta;
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------
	// Event pulse shaping
	// ----------------------------------------
	// Edge of the synchronised event levels; a source pulse shorter than one core
	// cycle can be missed, so sources are expected to hold events for that long
	reg  mic_prev;
	reg  seq_prev;
	wire mic_rise;
	wire seq_rise;
	wire mic_pulse;
	wire seq_pulse;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mic_prev <= 1'b0;
			seq_prev <= 1'b0;
		end else begin
			mic_prev <= src[14];
			seq_prev <= src[15];
		end
	end

	assign mic_rise = src[14] & ~mic_prev;
	assign seq_rise = src[15] & ~seq_prev;

	// One 31 us pulse per accessory event
	gfsm_pulse_stretch #(
		.LEN (`GFSM_MIC_PULSE_CYC),
		.W   (`GFSM_MIC_CNT_W)
	) u_mic_pulse (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.trigger  (mic_rise),
		.pulse    (mic_pulse)
	);

	// Short completion pulse from the sequencer
	gfsm_pulse_stretch #(
		.LEN (`GFSM_SEQ_PULSE_CYC),
		.W   (`GFSM_MIC_CNT_W)
	) u_seq_pulse (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.trigger  (seq_rise),
		.pulse    (seq_pulse)
	);

	// ----------------------------------------
	// Function decode
	// ----------------------------------------
	// Fifth pin subset: static level, interrupts, loop lock and address error flags, mic and sequencer events, no fast clocks or streams
	function fifth_pin_allows;
		input [6:0] fn;
		begin
			case (fn)
				`GFSM_FN_NONE, `GFSM_FN_LEVEL, `GFSM_FN_IRQ_ONE, `GFSM_FN_IRQ_TWO,
				`GFSM_FN_LOOP1_LOCK, `GFSM_FN_LOOP2_LOCK, `GFSM_FN_MIC_DETECT,
				`GFSM_FN_SEQ_DONE, `GFSM_FN_ADDR_ERR: fifth_pin_allows = 1'b1;
				default: fifth_pin_allows = 1'b0;
			endcase
		end
	endfunction

	// Selected source for a code; unassigned codes give low
	function select_source;
		input [6:0]      fn;
		input            level;
		input [NSRC-1:0] s;
		input            mic_p;
		input            seq_p;
		begin
			case (fn)
				`GFSM_FN_LEVEL:       select_source = level;
				`GFSM_FN_IRQ_ONE:     select_source = s[0];
				`GFSM_FN_IRQ_TWO:     select_source = s[1];
				`GFSM_FN_DERIVED_CLK: select_source = s[2];
				`GFSM_FN_LOOP1_CLK:   select_source = s[3];
				`GFSM_FN_LOOP2_CLK:   select_source = s[4];
				`GFSM_FN_SPDIF:       select_source = s[5];
				`GFSM_FN_PULSE_WIDTH_CHANNEL_ONE:        select_source = s[6];
				`GFSM_FN_PULSE_WIDTH_CHANNEL_TWO:        select_source = s[7];
				`GFSM_FN_SYS_UNDER:   select_source = s[8];
				`GFSM_FN_ASYNC_UNDER: select_source = s[9];
				`GFSM_FN_LOOP1_LOCK:  select_source = s[10];
				`GFSM_FN_LOOP2_LOCK:  select_source = s[11];
				`GFSM_FN_LOOP1_OK:    select_source = s[12];
				`GFSM_FN_LOOP2_OK:    select_source = s[13];
				`GFSM_FN_MIC_DETECT:  select_source = mic_p;
				`GFSM_FN_SEQ_DONE:    select_source = seq_p;
				`GFSM_FN_ADDR_ERR:    select_source = s[16];
				`GFSM_FN_ARC1_LOCK:   select_source = s[17];
				`GFSM_FN_ARC2_LOCK:   select_source = s[18];
				`GFSM_FN_ARC_CFG_ERR: select_source = s[19];
				`GFSM_FN_DYN_SIGNAL:  select_source = s[20];
				`GFSM_FN_DYN_CLIP:    select_source = s[21];
				`GFSM_FN_DYN_DECAY:   select_source = s[22];
				`GFSM_FN_DYN_GATE:    select_source = s[23];
				`GFSM_FN_DYN_QUICK:   select_source = s[24];
				default:              select_source = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Per-pin output stage
	// ----------------------------------------
	// The decode reads src in packing order; event bits 14 and 15 go through the stretchers
	genvar p;
	generate
		for (p = 0; p < NPIN; p = p + 1) begin : g_pin
			wire [6:0] fn;
			wire       allowed;
			wire       raw;
			wire       drive;
			wire       is_out;
			wire       next_out;
			wire       next_oe;

			assign fn      = pin_function_select[p*7 + `GFSM_FN_MSB -: 7];
			assign allowed = (p < NPIN - 1) ? 1'b1 : fifth_pin_allows(fn);
			assign raw     = allowed ? select_source(fn, pin_level_bit[p], src, mic_pulse, seq_pulse) : 1'b0;
			assign is_out  = (pin_direction[p] == `GFSM_DIR_OUTPUT);
			// Code 00h leaves the pin undriven even with direction set to output
			assign drive   = is_out && (fn != `GFSM_FN_NONE);
			assign next_out = drive ? (raw ^ output_polarity[p]) : 1'b0;
			assign next_oe  = drive;

			// Registered pin drive; input pins never drive, so polarity leaves reads alone
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_out[p]        <= 1'b0;
					pin_oe[p]         <= 1'b0;
					pin_level_read[p] <= 1'b0;
				end else begin
					pin_out[p]        <= next_out;
					pin_oe[p]         <= next_oe;
					pin_level_read[p] <= pin_sync[p];
				end
			end
		end
	endgenerate
endmodule // gfsm_pin_mux

/* dv/gfsm_assertions.sv */
// Port checks for the pin multiplexer, on pins 0 and 4.
// Assumes one core_clk domain; bound to gfsm_pin_mux at the foot.
`timescale 1ns/1ps
`include "gfsm_defines.vh"
module gfsm_assertions (
	input wire        core_clk,
	input wire        rst_n,
	input wire [34:0] pin_function_select,
	input wire [4:0]  pin_direction,
	input wire [4:0]  pin_level_bit,
	input wire [4:0]  output_polarity,
	input wire        interrupt_line_one,
	input wire        control_address_error,
	input wire [4:0]  pin_out,
	input wire [4:0]  pin_oe
);
	// ----
	// Properties
	// ----
	wire [6:0] fn0  = pin_function_select[6:0];
	wire [6:0] fn4  = pin_function_select[34:28];
	wire       out0 = !pin_direction[0] && !output_polarity[0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Sources take three edges, so the selection must stand four
	sequence s_irq0;
		fn0 == `GFSM_FN_IRQ_ONE && !pin_direction[0];
	endsequence
	sequence s_flag4;
		fn4 == `GFSM_FN_ADDR_ERR && !pin_direction[4] && !output_polarity[4];
	endsequence
	// A rise with the code steady can only come from the event logic
	sequence s_rise(code);
		$rose(pin_out[0]) && out0 && fn0 == code && $past(fn0) == code && $past(fn0, 2) == code;
	endsequence
	a_level_drive: assert property (fn0 == `GFSM_FN_LEVEL && !pin_direction[0] |=>
		pin_oe[0] && pin_out[0] == ($past(pin_level_bit[0]) ^ $past(output_polarity[0]))) else $error("level");
	a_input_idle: assert property (pin_direction[0] |=> !pin_oe[0] && !pin_out[0]) else $error("input");
	a_irq_follow: assert property (s_irq0[*4] |->
		pin_out[0] == ($past(interrupt_line_one, 3) ^ $past(output_polarity[0]))) else $error("irq");
	a_reserved_low: assert property ((fn0 == 7'h0e || fn0 == `GFSM_FN_HP_DETECT) && out0 |=>
		pin_oe[0] && !pin_out[0]) else $error("reserved");
	a_fifth_subset: assert property (fn4 == `GFSM_FN_DERIVED_CLK && !pin_direction[4]
		&& !output_polarity[4] |=> pin_oe[4] && !pin_out[4]) else $error("fifth subset");
	a_fifth_flag: assert property (s_flag4[*4] |->
		pin_out[4] == $past(control_address_error, 3)) else $error("fifth flag");
	a_mic_width: assert property (s_rise(`GFSM_FN_MIC_DETECT) |-> pin_out[0][*8]) else $error("mic");
	a_seq_width: assert property (s_rise(`GFSM_FN_SEQ_DONE) |-> pin_out[0][*4]) else $error("seq");
endmodule // gfsm_assertions

bind gfsm_pin_mux gfsm_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.pin_function_select(pin_function_select), .pin_direction(pin_direction),
	.pin_level_bit(pin_level_bit), .output_polarity(output_polarity), .pin_out(pin_out), .pin_oe(pin_oe),
	.interrupt_line_one(interrupt_line_one), .control_address_error(control_address_error));

/* dv/gfsm_board_model.sv */
// Board model: reads each pin, with a pull-down and an optional board driver.
// Assumes the bench driver can stay enabled on a pin set as output (pin 0 after t_pin0); the device drive wins there.
`timescale 1ns/1ps
module gfsm_board_model (
	input  wire [4:0] pin_out,
	input  wire [4:0] pin_oe,
	input  wire [4:0] ext_en,
	output wire [4:0] pin_in
);
	// Device drive first, then the board driver; a free pin falls to the pull-down
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en);
endmodule // gfsm_board_model

/* dv/gpio_function_select_mux_test.sv */
// Self-checking bench for the pin function multiplexer, one task per scenario.
// Assumes the design, board model and checker are compiled before it.
`timescale 1ns/1ps
`include "gfsm_defines.vh"
`define chk(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module gpio_function_select_mux_test;
	reg         core_clk;
	reg         rst_n;
	reg  [34:0] fsel;
	reg  [4:0]  dir, lvl, pol, ext_en;
	reg  [24:0] src;
	wire [4:0]  pin_out, pin_oe, pin_rd, pin_in;
	integer     bad_count, n_compared;
	// ----
	// Design and board
	// ----
	gfsm_pin_mux u_dut (.core_clk(core_clk), .rst_n(rst_n), .pin_function_select(fsel), .pin_direction(dir),
		.pin_level_bit(lvl), .output_polarity(pol), .pin_in(pin_in), .interrupt_line_one(src[0]),
		.interrupt_line_two(src[1]), .derived_clock_out(src[2]), .locked_loop_one_clk(src[3]),
		.locked_loop_two_clk(src[4]), .spdif_stream(src[5]), .pulse_width_channel_one(src[6]),
		.pulse_width_channel_two(src[7]), .system_clock_underclocked(src[8]), .async_clock_underclocked(src[9]),
		.locked_loop_one_lock(src[10]), .locked_loop_two_lock(src[11]), .locked_loop_one_ok(src[12]),
		.locked_loop_two_ok(src[13]), .mic_accessory_detect_event(src[14]), .sequencer_done_event(src[15]),
		.control_address_error(src[16]), .async_rate_converter_one_lock(src[17]),
		.async_rate_converter_two_lock(src[18]), .async_rate_converter_config_error(src[19]),
		.dynamics_processor_one_signal(src[20]), .dynamics_processor_one_clip(src[21]),
		.dynamics_processor_one_decay(src[22]), .dynamics_processor_one_gate(src[23]),
		.dynamics_processor_one_quick(src[24]), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level_read(pin_rd));
	gfsm_board_model u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .pin_in(pin_in));
	// ----
	// Scenarios
	// ----
	task wt(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	// Pin 0 as output; four edges cover the two sync flops and the output flop
	task sel0(input [6:0] c, input p);
		begin
			fsel[6:0] = c;
			dir[0] = 1'b0;
			pol[0] = p;
			wt(4);
		end
	endtask
	// Every code on each of the five pins, levels high and events quiet
	task t_codes;
		integer p, c;
		reg e;
		begin
			src = ~25'h0_c000;
			for (p = 0; p < 5; p++) begin
				dir[p] = 1'b0;
				for (c = 0; c < 128; c++) begin
					fsel[p*7 +: 7] = c[6:0];
					wt(4);
					e = c == 2 || c == 3 || c == 12 || c == 13 || c == 22;
					if (p < 4)
						e = e || (c > 1 && c < 17 && c != 14) || (c > 25 && c < 34);
					`chk("code", {c != 0, e}, {pin_oe[p], pin_out[p]})
				end
			end
		end
	endtask
	// Each level source alone, others at the opposite level, both polarities
	task t_sources;
		integer i, k, v;
		reg [6:0] c;
		begin
			for (i = 0; i < 50; i++) begin
				k = i % 25;
				c = 7'(k < 12 ? k + 2 : k < 14 ? k + 3 : k == 16 ? 22 : k + 9);
				for (v = 0; v < 2 && (k < 14 || k > 15); v++) begin
					src = (v ? 25'h1 << k : ~(25'h1 << k)) & ~25'h0_c000;
					sel0(c, i > 24);
					`chk("source", v[0] ^ (i > 24), pin_out[0])
				end
			end
		end
	endtask
	// Static level out and logic input in; read-back of an input pin ignores polarity
	task t_pin0;
		integer i;
		begin
			fsel[6:0] = `GFSM_FN_LEVEL;
			for (i = 0; i < 8; i++) begin
				{dir[0], pol[0], lvl[0], ext_en[0]} = {i[2:0], i[0] & i[2]};
				wt(4);
				`chk("level", {!i[2], !i[2] && (i[0] ^ i[1]), i[2] ? i[0] : i[0] ^ i[1]},
					{pin_oe[0], pin_out[0], pin_rd[0]})
			end
		end
	endtask
	// One event, then the pulse length on pin 0 is counted
	task t_pulse(input [6:0] c, input integer k, input integer len);
		integer n;
		begin
			src = 25'h000_0000;
			sel0(c, 1'b0);
			src[k] = 1'b1;
			wt(2);
			src[k] = 1'b0;
			for (n = 0; pin_out[0] !== 1'b1 && n < 20; n++)
				wt(1);
			if (n == 20) begin
				bad_count++;
				complete_run;
			end
			for (n = 0; pin_out[0] === 1'b1 && n < 9000; n++)
				wt(1);
			`chk("pulse", len, n)
		end
	endtask
	task complete_run;
		begin
			$display("compared %0d mismatched %0d", n_compared, bad_count);
			if (bad_count == 0 && n_compared > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// Free-running core clock, 5 ns period
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Reset four cycles with every pin an input, then each scenario in turn
	initial begin
		{rst_n, dir, lvl, pol, ext_en, src} = {1'b0, 5'h1f, 15'h0000, 25'h000_0000};
		fsel = {5{`GFSM_FN_LEVEL}};
		bad_count = 0;
		n_compared = 0;
		wt(4);
		rst_n = 1'b1;
		wt(4);
		`chk("idle", 10'h000, {pin_oe, pin_out})
		t_codes;
		t_sources;
		t_pin0;
		t_pulse(`GFSM_FN_MIC_DETECT, 14, `GFSM_MIC_PULSE_CYC);
		t_pulse(`GFSM_FN_SEQ_DONE, 15, `GFSM_SEQ_PULSE_CYC);
		complete_run;
	end
endmodule // gpio_function_select_mux_test
